// ===== core/cog_event_input_select.v
// Event input qualification for the complementary output generator
//
// Contract
// - Enabled source, rising mode one: low-to-high edge gives rising event after phase delay.
// - Enabled source, rising mode zero: high level gives immediate rising event.
// - Cleared rising enable bit: source ignored for rising events, whatever its mode.
// - Rising mode register holds one mode bit per source, bits 7 to 0.
// - Rising mode bit 0 governs the remapped pin source, only when enabled.
// - Falling select register holds eight enable bits in rising source order.
// - Cleared falling enable bit keeps its source out of the falling event.
// - Enabled source, falling mode one: high-to-low edge gives falling event after delay.
// - Enabled source, falling mode zero: low level gives immediate falling event.
// - Cleared falling enable bit: source ignored for falling events, whatever its mode.
// - Mode and select registers are read/write and reset to zero.
// - Separate eight-bit rising source select register enables each rising source.
// - Falling mode bit 0 governs the enabled remapped pin source.
//
// The implementer's own choices: the APB register port and the placing of the registers.
`include "cog_event_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module cog_event_input_select (
    input wire clk_sys,
    input wire rst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [`ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire freq_oscillator_output,
    input wire third_pulse_modulator_output,
    input wire second_capture_compare_output,
    input wire first_capture_compare_output,
    input wire first_logic_cell_output,
    input wire comparator_two_output,
    input wire comparator_one_output,
    input wire remapped_pin_select,
    output reg rising_event,
    output reg falling_event
);

    reg [7:0] rising_source_select;
    reg [7:0] rising_event_mode;
    reg [7:0] falling_event_source_select;
    reg [7:0] falling_event_mode;
    reg [7:0] rising_phase_delay;
    reg [7:0] falling_phase_delay;

    reg pin_s1;
    reg pin_s2;
    reg pin_s3;
    reg pin_level;
    reg [7:0] src_prev;
    reg [7:0] rise_count;
    reg [7:0] fall_count;
    reg rise_busy;
    reg fall_busy;

    wire [7:0] src_now;
    wire [7:0] rise_edge_hit;
    wire [7:0] rise_level_hit;
    wire [7:0] fall_edge_hit;
    wire [7:0] fall_level_hit;
    wire any_rise_edge;
    wire any_fall_edge;
    wire any_rise_level;
    wire any_fall_level;
    wire rise_delay_done;
    wire fall_delay_done;
    wire access;
    wire wr_en;
    reg next_pslverr;
    reg [31:0] next_prdata;

    // Pin needs a three-stage front end; the second and third stages must agree
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
            pin_s3 <= 1'b0;
            pin_level <= 1'b0;
        end else begin
            pin_s1 <= remapped_pin_select;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            if (pin_s2 == pin_s3) begin
                pin_level <= pin_s3;
            end
        end
    end

    // On-chip sources share this clock, so they are taken directly
    assign src_now = {freq_oscillator_output, third_pulse_modulator_output,
                      second_capture_compare_output, first_capture_compare_output,
                      first_logic_cell_output, comparator_two_output,
                      comparator_one_output, pin_level};

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            src_prev <= 8'h00;
        end else begin
            src_prev <= src_now;
        end
    end

    // Per-source qualification
    genvar i;
    generate
        for (i = 0; i < `SRC_COUNT; i = i + 1) begin : g_src
            // Enable gates both modes, so a cleared enable hides the source
            assign rise_edge_hit[i] = rising_source_select[i] & rising_event_mode[i]
                                      & src_now[i] & ~src_prev[i];
            assign rise_level_hit[i] = rising_source_select[i] & ~rising_event_mode[i]
                                       & src_now[i];
            assign fall_edge_hit[i] = falling_event_source_select[i] & falling_event_mode[i]
                                      & ~src_now[i] & src_prev[i];
            assign fall_level_hit[i] = falling_event_source_select[i] & ~falling_event_mode[i]
                                       & ~src_now[i];
        end
    endgenerate

    assign any_rise_edge = |rise_edge_hit;
    assign any_rise_level = |rise_level_hit;
    assign any_fall_edge = |fall_edge_hit;
    assign any_fall_level = |fall_level_hit;

    // Phase delay: an edge starts the count, a new edge restarts it
    assign rise_delay_done = rise_busy & (rise_count == 8'h00);
    assign fall_delay_done = fall_busy & (fall_count == 8'h00);

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rise_count <= 8'h00;
            rise_busy <= 1'b0;
        end else if (any_rise_edge) begin
            rise_count <= rising_phase_delay;
            rise_busy <= 1'b1;
        end else if (rise_delay_done) begin
            rise_busy <= 1'b0;
        end else if (rise_busy) begin
            rise_count <= rise_count - 8'h01;
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fall_count <= 8'h00;
            fall_busy <= 1'b0;
        end else if (any_fall_edge) begin
            fall_count <= falling_phase_delay;
            fall_busy <= 1'b1;
        end else if (fall_delay_done) begin
            fall_busy <= 1'b0;
        end else if (fall_busy) begin
            fall_count <= fall_count - 8'h01;
        end
    end

    // Level triggers bypass the delay; outputs registered for clean timing
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rising_event <= 1'b0;
            falling_event <= 1'b0;
        end else begin
            rising_event <= any_rise_level | rise_delay_done;
            falling_event <= any_fall_level | fall_delay_done;
        end
    end

    // APB slave: one wait state so read data comes from a flop
    assign access = psel & penable & ~pready;
    assign wr_en = psel & penable & pready & pwrite & ~pslverr;

    always @* begin
        next_pslverr = 1'b0;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `OFS_RISING_SOURCE_SELECT: next_prdata[7:0] = rising_source_select;
            `OFS_RISING_EVENT_MODE: next_prdata[7:0] = rising_event_mode;
            `OFS_FALLING_EVENT_SOURCE_SELECT: next_prdata[7:0] = falling_event_source_select;
            `OFS_FALLING_EVENT_MODE: next_prdata[7:0] = falling_event_mode;
            `OFS_RISING_PHASE_DELAY: next_prdata[7:0] = rising_phase_delay;
            `OFS_FALLING_PHASE_DELAY: next_prdata[7:0] = falling_phase_delay;
            `OFS_EVENT_STATUS: begin
                next_prdata[`STAT_SRC_LSB+7:`STAT_SRC_LSB] = src_now;
                next_prdata[`STAT_RISE_BUSY_BIT] = rise_busy;
                next_prdata[`STAT_FALL_BUSY_BIT] = fall_busy;
            end
            default: next_pslverr = 1'b1;
        endcase
        if (pwrite) begin
            next_prdata = 32'h0000_0000;
            if (paddr == `OFS_EVENT_STATUS) begin
                next_pslverr = 1'b1;
            end
        end
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access & next_pslverr;
            if (access) begin
                prdata <= next_prdata;
            end else begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // Only the low byte is stored; upper write data is dropped
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rising_source_select <= `RST_SELECT;
            rising_event_mode <= `RST_MODE;
            falling_event_source_select <= `RST_SELECT;
            falling_event_mode <= `RST_MODE;
            rising_phase_delay <= `RST_DELAY;
            falling_phase_delay <= `RST_DELAY;
        end else if (wr_en) begin
            case (paddr)
                `OFS_RISING_SOURCE_SELECT: rising_source_select <= pwdata[7:0];
                `OFS_RISING_EVENT_MODE: rising_event_mode <= pwdata[7:0];
                `OFS_FALLING_EVENT_SOURCE_SELECT: falling_event_source_select <= pwdata[7:0];
                `OFS_FALLING_EVENT_MODE: falling_event_mode <= pwdata[7:0];
                `OFS_RISING_PHASE_DELAY: rising_phase_delay <= pwdata[7:0];
                `OFS_FALLING_PHASE_DELAY: falling_phase_delay <= pwdata[7:0];
                default: rising_phase_delay <= rising_phase_delay;
            endcase
        end
    end

endmodule

`default_nettype wire

// ===== core/cog_event_defs.vh
// Register offsets, reset values and widths for the event input select block
`ifndef COG_EVENT_DEFS_VH
`define COG_EVENT_DEFS_VH

`define SRC_COUNT 8
`define ADDR_W 12
`define OFS_RISING_SOURCE_SELECT 12'h000
`define OFS_RISING_EVENT_MODE 12'h004
`define OFS_FALLING_EVENT_SOURCE_SELECT 12'h008
`define OFS_FALLING_EVENT_MODE 12'h00C
`define OFS_RISING_PHASE_DELAY 12'h010
`define OFS_FALLING_PHASE_DELAY 12'h014
`define OFS_EVENT_STATUS 12'h018
`define RST_SELECT 8'h00
`define RST_MODE 8'h00
`define RST_DELAY 8'h00
`define SRC_PIN_BIT 0
`define STAT_SRC_LSB 0
`define STAT_RISE_BUSY_BIT 8
`define STAT_FALL_BUSY_BIT 9

`endif

// ===== bench/cog_event_src_model.sv
// Model of the on-chip sources feeding the event inputs
`timescale 1ns/100ps
`default_nettype none
module cog_event_src_model (
    input wire logic clk_sys,
    output var logic [7:0] src
);
    initial src = 8'h00;
    // Same-clock sources only move just after an edge
    task automatic drive(input logic [7:0] v);
        @(posedge clk_sys);
        src <= v;
    endtask
endmodule
`default_nettype wire

// ===== bench/cog_event_input_select_chk.sv
// Checker of APB answers and event qualification
`timescale 1ns/100ps
`default_nettype none
`include "cog_event_defs.vh"
module cog_event_input_select_chk (
    input wire logic clk_sys, rst, psel, penable, pwrite, pready, pslverr,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata, prdata,
    input wire logic freq_oscillator_output, third_pulse_modulator_output,
    input wire logic second_capture_compare_output, first_capture_compare_output,
    input wire logic first_logic_cell_output, comparator_two_output, comparator_one_output,
    input wire logic remapped_pin_select, rising_event, falling_event
);
    logic [7:0] sh [0:5];
    wire logic [7:0] s = {freq_oscillator_output, third_pulse_modulator_output,
        second_capture_compare_output, first_capture_compare_output, first_logic_cell_output,
        comparator_two_output, comparator_one_output, remapped_pin_select};
    // Pin left out: its synchroniser adds latency
    wire logic [7:0] rl = sh[0] & ~sh[1] & s & 8'hFE;
    wire logic [7:0] fl = sh[2] & ~sh[3] & ~s & 8'hFE;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 6; i++) sh[i] <= 8'h00;
        end else if (psel && penable && pready && pwrite && !pslverr && paddr < 12'h018) begin
            sh[paddr[4:2]] <= pwdata[7:0];
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    a_ready_answer: assert property (psel && penable && !pready |=> pready) else $error("no pready");
    a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
    a_rdata_idle: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
        else $error("prdata not zero");
    a_err_unmapped: assert property (pready && paddr > 12'h018 |-> pslverr) else $error("no error");
    a_err_status: assert property (pready && pwrite && paddr == 12'h018 |-> pslverr)
        else $error("status write accepted");
    a_rise_level: assert property (|rl |=> rising_event) else $error("rise level missed");
    a_fall_level: assert property (|fl |=> falling_event) else $error("fall level missed");
    a_rise_edge: assert property (sh[4] == 8'h00 && |(sh[0] & sh[1] & s & ~$past(s) & 8'hFE)
        |-> ##2 rising_event) else $error("rise edge missed");
    a_fall_edge: assert property (sh[5] == 8'h00 && |(sh[2] & sh[3] & ~s & $past(s) & 8'hFE)
        |-> ##2 falling_event) else $error("fall edge missed");
    c_err: cover property (pready && pslverr);
    c_rise_pulse: cover property (rising_event ##1 !rising_event);
    c_fall: cover property (falling_event);
endmodule
bind cog_event_input_select cog_event_input_select_chk u_chk (.*);
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the event input select block
`timescale 1ns/100ps
`default_nettype none
`include "cog_event_defs.vh"
module tb;
    logic clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [`ADDR_W-1:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, rising_event, falling_event;
    logic [7:0] src;
    logic [7:0] m [0:5] = '{default: 8'h00};
    logic [7:0] cfg [0:5] = '{8'h02, 8'hFF, 8'h02, 8'hFF, 8'h03, 8'h03};
    int mismatches = 0, n_compared = 0, seed = 34, n;
    always #5 clk_sys = ~clk_sys;
    cog_event_src_model u_cog_event_src_model (.clk_sys(clk_sys), .src(src));
    cog_event_input_select u_cog_event_input_select (.clk_sys(clk_sys), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .freq_oscillator_output(src[7]),
        .third_pulse_modulator_output(src[6]), .second_capture_compare_output(src[5]),
        .first_capture_compare_output(src[4]), .first_logic_cell_output(src[3]),
        .comparator_two_output(src[2]), .comparator_one_output(src[1]),
        .remapped_pin_select(src[0]), .rising_event(rising_event), .falling_event(falling_event));
    task automatic chk(input string what, input logic [31:0] exp, got);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (w && a < 12'h018) m[a[4:2]] = d[7:0];
    endtask
    task automatic rdchk(input logic [11:0] a);
        apb(1'b0, a, 32'h0);
        chk("prdata", a < 12'h018 ? {24'h0, m[a[4:2]]} : 32'h0, rd);
        chk("pslverr", a > 12'h018, err);
    endtask
    // Counts edges from the source change to the event pulse
    task automatic lat(input logic [7:0] v);
        u_cog_event_src_model.drive(v);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (rising_event !== 1'b1 && falling_event !== 1'b1 && n < 20);
        chk("event delay", 32'h5, n);
        @(posedge clk_sys);
        #1;
        chk("event pulse", 32'h0, {rising_event, falling_event});
    endtask
    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #100000;
        mismatches++;
        stop_test;
    end
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a < 24; a += 4) rdchk(a[11:0]);
        rdchk(12'h01C);
        apb(1'b1, 12'h018, 32'hFF);
        chk("status write error", 32'h1, err);
        $display("test reset and map done");
        for (int a = 0; a < 16; a += 4) begin
            apb(1'b1, a[11:0], $random(seed));
            rdchk(a[11:0]);
        end
        $display("test readback done");
        // Delays stay zero so edge pulses have died out before sampling
        for (int k = 0; k < 24; k++) begin
            for (int a = 0; a < 16; a += 4) apb(1'b1, a[11:0], $random(seed));
            u_cog_event_src_model.drive(8'($random(seed)));
            repeat (8) @(posedge clk_sys);
            #1;
            chk("rising_event", |(m[0] & ~m[1] & src), rising_event);
            chk("falling_event", |(m[2] & ~m[3] & ~src), falling_event);
            apb(1'b0, 12'h018, 32'h0);
            chk("status", {24'h0, src}, rd);
            chk("status pslverr", 32'h0, err);
        end
        $display("test levels done");
        for (int a = 0; a < 6; a++) apb(1'b1, 12'(a * 4), {24'h0, cfg[a]});
        rdchk(12'h010);
        rdchk(12'h014);
        u_cog_event_src_model.drive(8'h00);
        repeat (8) @(posedge clk_sys);
        lat(8'h02);
        lat(8'h00);
        $display("test edge delay done");
        stop_test;
    end
endmodule
`default_nettype wire
